// file: core/fms_defines.svh
// Constants for the flash mode switch and soft reset block
`ifndef FMS_DEFINES_SVH
`define FMS_DEFINES_SVH

// ************************************************************
// Command opcodes
// ************************************************************
`define FMS_OP_WRAP_READ 8'h0C
`define FMS_OP_SET_PARAM 8'hC0
`define FMS_OP_QUAD_ON 8'h38
`define FMS_OP_QUAD_OFF 8'hFF
`define FMS_OP_RST_EN 8'h66
`define FMS_OP_RST 8'h99

// ************************************************************
// Read parameter field layout and reset values
// ************************************************************
`define FMS_DUMMY_SEL_HI 5
`define FMS_DUMMY_SEL_LO 4
`define FMS_WRAP_SEL_HI 1
`define FMS_WRAP_SEL_LO 0
`define FMS_RPARAM_RST 8'h00
`define FMS_LATCH_RST 1'b0
`define FMS_SUSPEND_RST 1'b0
`define FMS_CRM_RST 8'h00
`define FMS_WRAP_BITS_RST 3'h0
`define FMS_VSTAT_RST 8'h00

// Dummy clocks per select code
`define FMS_DUMMY_0 4'h2
`define FMS_DUMMY_1 4'h4
`define FMS_DUMMY_2 4'h6
`define FMS_DUMMY_3 4'h8

// Wrap window masks per select code (8, 16, 32, 64 bytes)
`define FMS_WMASK_0 24'h000007
`define FMS_WMASK_1 24'h00000F
`define FMS_WMASK_2 24'h00001F
`define FMS_WMASK_3 24'h00003F

// ************************************************************
// Framing and timing
// ************************************************************
`define FMS_ADDR_BYTES 2'h3
`define FMS_QUAD_SAMPLES 3'h2
`define FMS_SPI_SAMPLES 3'h0
`define FMS_CLK_PERIOD_NS 20
`define FMS_RST_TIME_NS 30000
`define FMS_RST_CYCLES ((`FMS_RST_TIME_NS + `FMS_CLK_PERIOD_NS - 1) / `FMS_CLK_PERIOD_NS)
`define FMS_FIFO_WIDTH 5
`define FMS_FIFO_DEPTH 32

`endif

// file: core/fms_pkg.sv
// Types for the flash mode switch and soft reset block
package fms_pkg;

    typedef enum logic [2:0] {
        FMS_OPCODE,
        FMS_ADDR,
        FMS_DUMMY,
        FMS_STREAM,
        FMS_PARAM,
        FMS_SKIP,
        FMS_RST_WAIT
    } fms_state_e;

    typedef struct packed {
        fms_state_e state;
        logic quad_wire_command_mode;
        logic rst_armed;
        logic [7:0] read_parameter_field;
        logic write_enable_latch;
        logic suspend_status_flag;
        logic [7:0] continuous_read_mode_bits;
        logic [2:0] wrap_setting_bits;
        logic [7:0] vstat;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [1:0] addr_idx;
        logic [23:0] addr;
        logic [3:0] dummy_cnt;
        logic [10:0] rst_cnt;
        logic busy;
        logic abort;
        logic rd_valid;
        logic [23:0] rd_addr;
    } fms_core_s;

    typedef struct packed {
        logic first;
    } fms_link_s;

endpackage

// file: core/fms_link_fifo.sv
// Dual-clock FIFO carrying link samples into the core clock domain
`timescale 1ns/10ps
module fms_link_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    // Write side, link clock
    input wire logic w_clk,
    input wire logic w_rst_n,
    input wire logic w_valid,
    input wire logic [WIDTH-1:0] w_data,
    output logic w_ready,
    // Read side, core clock
    input wire logic r_clk,
    input wire logic r_rst_n,
    output logic r_valid,
    output logic [WIDTH-1:0] r_data,
    input wire logic r_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin;
    logic [AW:0] wgray;
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] rgray_w1;
    logic [AW:0] rgray_w2;
    logic [AW:0] wgray_r1;
    logic [AW:0] wgray_r2;
    logic [AW:0] wbin_next;
    logic [AW:0] rbin_next;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    // Full when write pointer leads read by exactly one lap
    assign w_ready = (wgray != {~rgray_w2[AW:AW-1], rgray_w2[AW-2:0]});
    assign r_valid = (rgray != wgray_r2);
    assign r_data = mem[rbin[AW-1:0]];
    assign wbin_next = wbin + (AW+1)'(1);
    assign rbin_next = rbin + (AW+1)'(1);

    always_ff @(posedge w_clk)
    begin
        if (w_valid && w_ready)
        begin
            mem[wbin[AW-1:0]] <= w_data;
        end
    end

    always_ff @(posedge w_clk or negedge w_rst_n)
    begin
        if (!w_rst_n)
        begin
            wbin <= '0;
            wgray <= '0;
            rgray_w1 <= '0;
            rgray_w2 <= '0;
        end
        else
        begin
            rgray_w1 <= rgray;
            rgray_w2 <= rgray_w1;
            if (w_valid && w_ready)
            begin
                wbin <= wbin_next;
                wgray <= to_gray(wbin_next);
            end
        end
    end

    always_ff @(posedge r_clk or negedge r_rst_n)
    begin
        if (!r_rst_n)
        begin
            rbin <= '0;
            rgray <= '0;
            wgray_r1 <= '0;
            wgray_r2 <= '0;
        end
        else
        begin
            wgray_r1 <= wgray;
            wgray_r2 <= wgray_r1;
            if (r_valid && r_ready)
            begin
                rbin <= rbin_next;
                rgray <= to_gray(rbin_next);
            end
        end
    end
endmodule

// file: core/fms_mode_reset.sv
// Command interpreter for mode switching, wrapped burst read and soft reset
`timescale 1ns/10ps
`include "fms_defines.svh"
// What this block does
// - In quad mode the wrapped read acts as fast read, wrapping at window end.
// - Wrap length and dummy count come from the last loaded read parameters.
// - Quad mode entered only by enable command; exactly one mode active.
// - After power-up the block is in SPI mode.
// - Enable command ignored while the quad enable bit is zero.
// - Entering quad mode keeps write latch, suspend and wrap setting.
// - Disable command returns the block to SPI mode.
// - Leaving quad mode keeps write latch, suspend and wrap setting.
// - Accepted reset aborts operations and clears all volatile settings.
// - Reset acts only when reset-enable is immediately followed by reset.
// - Any other command after reset-enable disarms the reset.
// - For about 30us after reset every command is refused.
// - Defaults after power-up or reset: 8-byte wrap, 2 dummy clocks.
// - Dummy codes give 2,4,6,8 clocks; wrap codes give 8,16,32,64 bytes.
module fms_mode_reset #(
    parameter int FIFO_DEPTH = `FMS_FIFO_DEPTH,
    parameter int RST_CYCLES = `FMS_RST_CYCLES
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Link pins
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    // Device status inputs
    input wire logic quad_enable_bit,
    input wire logic latch_set,
    input wire logic latch_clr,
    input wire logic suspend_set,
    input wire logic suspend_clr,
    input wire logic crm_load,
    input wire logic [7:0] crm_value,
    input wire logic wrap_load,
    input wire logic [2:0] wrap_value,
    input wire logic vstat_load,
    input wire logic [7:0] vstat_value,
    // Mode and volatile state
    output logic quad_wire_command_mode,
    output logic [7:0] read_parameter_field,
    output logic write_enable_latch,
    output logic suspend_status_flag,
    output logic [7:0] continuous_read_mode_bits,
    output logic [2:0] wrap_setting_bits,
    output logic [7:0] vstat,
    output logic busy,
    output logic abort,
    // Wrapped read address stream
    output logic rd_valid,
    output logic [23:0] rd_addr,
    input wire logic rd_ready
);
    import fms_pkg::*;

    // ************************************************************
    // Link side
    // ************************************************************
    fms_link_s lk;
    fms_link_s next_lk;
    logic link_rst_n;
    logic w_ready;
    logic r_valid;
    logic r_ready;
    logic [`FMS_FIFO_WIDTH-1:0] r_data;

    // Frame start flag rearmed while chip select is high
    assign link_rst_n = reset_n & ~cs_n;

    always_comb
    begin
        next_lk = lk;
        if (w_ready)
        begin
            next_lk.first = 1'b0;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            lk <= '{first: 1'b1};
        end
        else
        begin
            lk <= next_lk;
        end
    end

    fms_link_fifo #(
        .WIDTH(`FMS_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .w_clk(link_clk),
        .w_rst_n(reset_n),
        .w_valid(~cs_n),
        .w_data({lk.first, io_in}),
        .w_ready(w_ready),
        .r_clk(core_clk),
        .r_rst_n(reset_n),
        .r_valid(r_valid),
        .r_data(r_data),
        .r_ready(r_ready)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [3:0] dummy_clocks(input logic [1:0] sel);
        case (sel)
            2'h0: dummy_clocks = `FMS_DUMMY_0;
            2'h1: dummy_clocks = `FMS_DUMMY_1;
            2'h2: dummy_clocks = `FMS_DUMMY_2;
            default: dummy_clocks = `FMS_DUMMY_3;
        endcase
    endfunction

    // Next address inside the aligned wrap window
    function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic [1:0] sel);
        logic [23:0] m;
        case (sel)
            2'h0: m = `FMS_WMASK_0;
            2'h1: m = `FMS_WMASK_1;
            2'h2: m = `FMS_WMASK_2;
            default: m = `FMS_WMASK_3;
        endcase
        wrap_next = (a & ~m) | ((a + 24'h000001) & m);
    endfunction

    // ************************************************************
    // Core side
    // ************************************************************
    fms_core_s cs;
    fms_core_s next_cs;
    logic take;
    logic sof;
    fms_state_e st;
    logic [2:0] base;
    logic [2:0] cnt;
    logic [7:0] byte_v;
    logic done;
    logic [1:0] dsel;
    logic [1:0] wsel;

    // Samples wait while an emitted address is not taken
    assign r_ready = ~(cs.rd_valid & ~rd_ready);
    assign take = r_valid & r_ready;
    assign sof = r_data[`FMS_FIFO_WIDTH-1];
    assign dsel = cs.read_parameter_field[`FMS_DUMMY_SEL_HI:`FMS_DUMMY_SEL_LO];
    assign wsel = cs.read_parameter_field[`FMS_WRAP_SEL_HI:`FMS_WRAP_SEL_LO];

    always_comb
    begin
        next_cs = cs;
        next_cs.abort = 1'b0;
        st = (sof && cs.state != FMS_RST_WAIT) ? FMS_OPCODE : cs.state;
        base = sof ? 3'h0 : cs.bit_cnt;
        cnt = base + 3'h1;
        byte_v = cs.quad_wire_command_mode ? {cs.shift[3:0], r_data[3:0]}
                                           : {cs.shift[6:0], r_data[0]};
        done = cs.quad_wire_command_mode ? (cnt == `FMS_QUAD_SAMPLES)
                                         : (cnt == `FMS_SPI_SAMPLES);
        if (cs.rd_valid && rd_ready)
        begin
            next_cs.rd_valid = 1'b0;
        end
        // Volatile bits driven by the rest of the device, set wins
        if (latch_clr)
        begin
            next_cs.write_enable_latch = 1'b0;
        end
        if (latch_set)
        begin
            next_cs.write_enable_latch = 1'b1;
        end
        if (suspend_clr)
        begin
            next_cs.suspend_status_flag = 1'b0;
        end
        if (suspend_set)
        begin
            next_cs.suspend_status_flag = 1'b1;
        end
        if (crm_load)
        begin
            next_cs.continuous_read_mode_bits = crm_value;
        end
        if (wrap_load)
        begin
            next_cs.wrap_setting_bits = wrap_value;
        end
        if (vstat_load)
        begin
            next_cs.vstat = vstat_value;
        end
        if (cs.state == FMS_RST_WAIT)
        begin
            // Samples are drained and dropped while the reset runs
            next_cs.rst_cnt = cs.rst_cnt - 11'h001;
            if (cs.rst_cnt == 11'h001)
            begin
                next_cs.state = FMS_SKIP;
                next_cs.busy = 1'b0;
            end
        end
        else if (take)
        begin
            next_cs.state = st;
            next_cs.shift = byte_v;
            next_cs.bit_cnt = done ? 3'h0 : cnt;
            case (st)
                FMS_OPCODE:
                begin
                    if (done)
                    begin
                        next_cs.state = FMS_SKIP;
                        next_cs.rst_armed = 1'b0;
                        case (byte_v)
                            `FMS_OP_RST_EN:
                            begin
                                next_cs.rst_armed = 1'b1;
                            end
                            `FMS_OP_RST:
                            begin
                                if (cs.rst_armed)
                                begin
                                    // Back to power-on state
                                    next_cs = '0;
                                    next_cs.state = FMS_RST_WAIT;
                                    next_cs.rst_cnt = 11'(RST_CYCLES);
                                    next_cs.busy = 1'b1;
                                    next_cs.abort = 1'b1;
                                    next_cs.read_parameter_field = `FMS_RPARAM_RST;
                                    next_cs.write_enable_latch = `FMS_LATCH_RST;
                                    next_cs.suspend_status_flag = `FMS_SUSPEND_RST;
                                    next_cs.continuous_read_mode_bits = `FMS_CRM_RST;
                                    next_cs.wrap_setting_bits = `FMS_WRAP_BITS_RST;
                                    next_cs.vstat = `FMS_VSTAT_RST;
                                end
                            end
                            `FMS_OP_QUAD_ON:
                            begin
                                // Other volatile state untouched
                                next_cs.quad_wire_command_mode |= quad_enable_bit;
                            end
                            `FMS_OP_QUAD_OFF:
                            begin
                                // Other volatile state untouched
                                next_cs.quad_wire_command_mode = 1'b0;
                            end
                            `FMS_OP_SET_PARAM:
                            begin
                                if (cs.quad_wire_command_mode)
                                begin
                                    next_cs.state = FMS_PARAM;
                                end
                            end
                            `FMS_OP_WRAP_READ:
                            begin
                                if (cs.quad_wire_command_mode)
                                begin
                                    next_cs.state = FMS_ADDR;
                                    next_cs.addr_idx = 2'h0;
                                end
                            end
                            default:
                            begin
                                next_cs.state = FMS_SKIP;
                            end
                        endcase
                    end
                end
                FMS_ADDR:
                begin
                    if (done)
                    begin
                        next_cs.addr = {cs.addr[15:0], byte_v};
                        next_cs.addr_idx = cs.addr_idx + 2'h1;
                        if (cs.addr_idx + 2'h1 == `FMS_ADDR_BYTES)
                        begin
                            next_cs.state = FMS_DUMMY;
                            next_cs.dummy_cnt = 4'h0;
                        end
                    end
                end
                FMS_DUMMY:
                begin
                    next_cs.bit_cnt = 3'h0;
                    next_cs.dummy_cnt = cs.dummy_cnt + 4'h1;
                    if (cs.dummy_cnt + 4'h1 == dummy_clocks(dsel))
                    begin
                        next_cs.state = FMS_STREAM;
                    end
                end
                FMS_STREAM:
                begin
                    // One address per data byte, first sample of the byte
                    if (base == 3'h0)
                    begin
                        next_cs.rd_valid = 1'b1;
                        next_cs.rd_addr = cs.addr;
                        next_cs.addr = wrap_next(cs.addr, wsel);
                    end
                end
                FMS_PARAM:
                begin
                    if (done)
                    begin
                        next_cs.read_parameter_field = byte_v;
                        next_cs.state = FMS_SKIP;
                    end
                end
                default:
                begin
                    next_cs.state = FMS_SKIP;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs <= '0;
        end
        else
        begin
            cs <= next_cs;
        end
    end

    assign quad_wire_command_mode = cs.quad_wire_command_mode;
    assign read_parameter_field = cs.read_parameter_field;
    assign write_enable_latch = cs.write_enable_latch;
    assign suspend_status_flag = cs.suspend_status_flag;
    assign continuous_read_mode_bits = cs.continuous_read_mode_bits;
    assign wrap_setting_bits = cs.wrap_setting_bits;
    assign vstat = cs.vstat;
    assign busy = cs.busy;
    assign abort = cs.abort;
    assign rd_valid = cs.rd_valid;
    assign rd_addr = cs.rd_addr;
endmodule

// file: dv/fms_mode_reset_sva.sv
// Concurrent checks on the ports of the mode switch and soft reset block
`timescale 1ns/10ps
module fms_mode_reset_sva #(
    parameter int RST_CYCLES = 1500
) (
    // Clock, reset and link
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic quad_enable_bit,
    // Mode and volatile state
    input wire logic quad_wire_command_mode,
    input wire logic [7:0] read_parameter_field,
    input wire logic write_enable_latch,
    input wire logic suspend_status_flag,
    input wire logic [7:0] continuous_read_mode_bits,
    input wire logic [2:0] wrap_setting_bits,
    input wire logic [7:0] vstat,
    input wire logic busy,
    input wire logic abort,
    // Address stream
    input wire logic rd_valid,
    input wire logic [23:0] rd_addr,
    input wire logic rd_ready
);
    logic [10:0] busy_len;
    logic [1:0] cs_sync;
    logic prev_ok;
    logic [23:0] prev_addr;
    logic [23:0] wmask;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ****************************************
    // Helpers: busy length, last accepted address
    // ****************************************
    assign wmask = (24'h000008 << read_parameter_field[1:0]) - 24'h000001;
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy_len <= 11'h000;
            cs_sync <= 2'h3;
            prev_ok <= 1'b0;
            prev_addr <= 24'h000000;
        end
        else
        begin
            busy_len <= busy ? busy_len + 11'h001 : 11'h000;
            cs_sync <= {cs_sync[0], cs_n};
            if (cs_sync[1])
                prev_ok <= 1'b0;
            else if (rd_valid && rd_ready)
                prev_ok <= 1'b1;
            if (rd_valid && rd_ready)
                prev_addr <= rd_addr;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    AST_POWER_ON: assert property ($rose(reset_n) |->
        !quad_wire_command_mode && read_parameter_field == 8'h00)
        else $error("mode or parameters wrong after reset");
    AST_ENABLE_GATE: assert property ($rose(quad_wire_command_mode) |-> $past(quad_enable_bit))
        else $error("quad mode entered without enable bit");
    AST_KEEP_ON_SWITCH: assert property ($changed(quad_wire_command_mode)
        && !busy && !abort && !$past(abort) |-> $stable(write_enable_latch)
        && $stable(suspend_status_flag) && $stable(wrap_setting_bits))
        else $error("state lost on mode switch");
    AST_ABORT_PULSE: assert property (abort |=> !abort)
        else $error("abort longer than one cycle");
    AST_ABORT_CLEARS: assert property (abort |-> ##[0:1] (!quad_wire_command_mode
        && !write_enable_latch && !suspend_status_flag && continuous_read_mode_bits == 8'h00
        && wrap_setting_bits == 3'h0 && vstat == 8'h00 && read_parameter_field == 8'h00))
        else $error("volatile state not cleared by reset");
    AST_BUSY_START: assert property (abort |-> ##[0:1] busy)
        else $error("busy not raised after reset");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_len == RST_CYCLES)
        else $error("reset wait has wrong length");
    AST_BUSY_FREEZE: assert property (busy && $past(busy, 2) |->
        $stable(quad_wire_command_mode) && $stable(read_parameter_field))
        else $error("command taken during reset wait");
    AST_RD_HOLD: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_addr))
        else $error("address dropped while stalled");
    AST_RD_WRAP: assert property (rd_valid && rd_ready && prev_ok |->
        rd_addr == ((prev_addr & ~wmask) | ((prev_addr + 24'h000001) & wmask)))
        else $error("wrapped address sequence wrong");
    COV_ABORT: cover property (abort);
    COV_QUAD: cover property ($rose(quad_wire_command_mode));
    COV_WRAP: cover property (rd_valid && rd_ready && prev_ok && (rd_addr & wmask) == 24'h0);
endmodule
bind fms_mode_reset fms_mode_reset_sva #(.RST_CYCLES(RST_CYCLES)) fms_mode_reset_sva_i (.*);

// file: dv/fms_host_model.sv
// Host controller model driving link clock, chip select and io pins
`timescale 1ns/10ps
module fms_host_model (
    // Link pins
    output logic link_clk,
    output logic cs_n,
    output logic [3:0] io_in
);
    logic quad;
    initial
    begin
        quad = 1'b0;
        link_clk = 1'b0;
        cs_n = 1'b1;
        io_in = 4'hA;
    end
    // ****************************************
    // Samples, bytes and frames
    // ****************************************
    // Gap after each pulse keeps the sample rate below the core drain rate
    task automatic sample(input logic [3:0] v);
        io_in = v;
        #3 link_clk = 1'b1;
        #3 link_clk = 1'b0;
        #18;
    endtask
    task automatic send_byte(input logic [7:0] b);
        if (quad)
        begin
            sample(b[7:4]);
            sample(b[3:0]);
        end
        else
            for (int i = 7; i >= 0; i--)
                sample({~io_in[3:1], b[i]});
    endtask
    task automatic filler(input int n);
        for (int i = 0; i < n; i++)
            sample(4'h5 ^ i[3:0]);
    endtask
    task automatic begin_frame();
        cs_n = 1'b0;
        #10;
    endtask
    // One command per frame; io shows inverse of last value when deselected
    task automatic end_frame();
        #10;
        cs_n = 1'b1;
        io_in = ~io_in;
        #40;
    endtask
endmodule

// file: dv/test_flash_mode_switch_and_soft_reset.sv
// Testbench for the mode switch and soft reset block
`timescale 1ns/10ps
`include "fms_defines.svh"
module test_flash_mode_switch_and_soft_reset;
    localparam int RST_PAR = 200;
    logic core_clk, reset_n, link_clk, cs_n, quad_enable_bit, latch_set, latch_clr, suspend_set;
    logic suspend_clr, crm_load, wrap_load, vstat_load, quad_wire_command_mode;
    logic write_enable_latch, suspend_status_flag, busy, abort, rd_valid, rd_ready;
    logic [3:0] io_in;
    logic [2:0] wrap_value, wrap_setting_bits;
    logic [7:0] crm_value, vstat_value, read_parameter_field, continuous_read_mode_bits, vstat;
    logic [23:0] rd_addr, start, mask;
    logic [23:0] got[$];
    int err_count, n_compared, n_abort, n_busy;
    fms_mode_reset #(.RST_CYCLES(RST_PAR)) fms_mode_reset_i (.*);
    fms_host_model fms_host_model_i (.*);
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
            got.push_back(rd_addr);
        if (abort === 1'b1)
            n_abort++;
        if (busy === 1'b1)
            n_busy++;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        fms_host_model_i.begin_frame();
        fms_host_model_i.send_byte(op);
        fms_host_model_i.end_frame();
        repeat (8) @(negedge core_clk);
    endtask
    task automatic check_kept();
        check("write latch", write_enable_latch, 1'b1);
        check("suspend", suspend_status_flag, 1'b1);
        check("wrap", wrap_setting_bits, 3'h5);
        check("crm", continuous_read_mode_bits, 8'hA5);
        check("vstat", vstat, 8'h3C);
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        {core_clk, reset_n, quad_enable_bit, latch_set, latch_clr, suspend_set, suspend_clr} = 7'h00;
        {crm_load, wrap_load, vstat_load, crm_value, wrap_value, vstat_value} = 22'h0;
        rd_ready = 1'b1;
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check("mode", quad_wire_command_mode, 1'b0);
        check("param", read_parameter_field, 8'h00);
        cmd(`FMS_OP_QUAD_ON);
        check("mode", quad_wire_command_mode, 1'b0);
        {latch_set, suspend_set, crm_load, wrap_load, vstat_load} = 5'h1F;
        {crm_value, wrap_value, vstat_value} = {8'hA5, 3'h5, 8'h3C};
        @(negedge core_clk);
        {latch_set, suspend_set, crm_load, wrap_load, vstat_load} = 5'h00;
        quad_enable_bit = 1'b1;
        cmd(`FMS_OP_QUAD_ON);
        fms_host_model_i.quad = 1'b1;
        check("mode", quad_wire_command_mode, 1'b1);
        check_kept();
        for (int c = 0; c < 4; c++)
        begin
            fms_host_model_i.begin_frame();
            fms_host_model_i.send_byte(`FMS_OP_SET_PARAM);
            fms_host_model_i.send_byte({2'h0, c[1:0], 2'h0, c[1:0]});
            fms_host_model_i.end_frame();
            repeat (8) @(negedge core_clk);
            check("param", read_parameter_field, {2'h0, c[1:0], 2'h0, c[1:0]});
            mask = (24'h000008 << c) - 24'h000001;
            start = 24'h1234C0 + mask - 24'h000001;
            got.delete();
            rd_ready = (c != 3);
            fms_host_model_i.begin_frame();
            fms_host_model_i.send_byte(`FMS_OP_WRAP_READ);
            for (int k = 2; k >= 0; k--)
                fms_host_model_i.send_byte(start[8*k +: 8]);
            fms_host_model_i.filler(2 * (c + 1) + 12);
            fms_host_model_i.end_frame();
            @(negedge core_clk);
            rd_ready = 1'b1;
            repeat (40) @(negedge core_clk);
            check("count", got.size(), 6);
            for (int i = 0; i < 6 && i < got.size(); i++)
                check("addr", got[i], (start & ~mask) | ((start + i) & mask));
        end
        cmd(`FMS_OP_QUAD_OFF);
        fms_host_model_i.quad = 1'b0;
        check("mode", quad_wire_command_mode, 1'b0);
        check_kept();
        cmd(`FMS_OP_RST_EN);
        cmd(8'h05);
        cmd(`FMS_OP_RST);
        check("aborts", n_abort, 0);
        check("write latch", write_enable_latch, 1'b1);
        {latch_set, latch_clr, suspend_clr} = 3'h7;
        @(negedge core_clk);
        {latch_set, latch_clr, suspend_clr} = 3'h0;
        check("write latch", write_enable_latch, 1'b1);
        check("busy", busy, 1'b0);
        check("suspend", suspend_status_flag, 1'b0);
        cmd(`FMS_OP_QUAD_ON);
        fms_host_model_i.quad = 1'b1;
        cmd(`FMS_OP_RST_EN);
        cmd(`FMS_OP_RST);
        fms_host_model_i.quad = 1'b0;
        check("aborts", n_abort, 1);
        check("busy", busy, 1'b1);
        check("cleared", {quad_wire_command_mode, read_parameter_field, write_enable_latch,
            suspend_status_flag, continuous_read_mode_bits, wrap_setting_bits, vstat}, 0);
        cmd(`FMS_OP_QUAD_ON);
        check("mode", quad_wire_command_mode, 1'b0);
        for (int w = 0; w < 400 && busy !== 1'b0; w++)
            @(negedge core_clk);
        check("busy len", n_busy, RST_PAR);
        cmd(`FMS_OP_QUAD_ON);
        check("mode", quad_wire_command_mode, 1'b1);
        give_verdict();
    end
    initial
    begin
        #500000;
        err_count++;
        give_verdict();
    end
endmodule
